// ==== shared/sipc_pkg.sv ====
/*
 * Package for the sleep/idle power controller: register offsets, field
 * positions, reset values, state codes and wake delay constants.
 * Assumes a 50 MHz system clock and a 32-bit classic Wishbone bus.
 */
`default_nettype none
package sipc_pkg;
    localparam int CLK_MHZ = 50;
    // Wake delays in their own unit, then in cycles (least times round up)
    localparam int POR_DELAY_NS = 10000;
    localparam int POR_DELAY_CYC = (POR_DELAY_NS * CLK_MHZ + 999) / 1000;
    localparam int POWERUP_TIMER_DELAY_US = 64;
    localparam int POWERUP_TIMER_DELAY_CYC = POWERUP_TIMER_DELAY_US * CLK_MHZ;
    localparam int OST_CYCLES = 1024;
    localparam int CNT_W = 16;
    // Register byte offsets
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_STATUS = 8'h04;
    localparam logic [7:0] REG_CONFIG = 8'h08;
    localparam logic [7:0] REG_PERIPH = 8'h0C;
    // Status field positions (reset control register)
    localparam int ST_WATCHDOG_TIMEOUT_FLAG = 4;
    localparam int ST_SLEEP = 3;
    localparam int ST_IDLE = 2;
    // Config field positions
    localparam int CF_CLKSW = 0;
    localparam int CF_WDT_EN = 1;
    localparam int CF_FAILSAFE_CLOCK_MONITOR_EN = 2;
    localparam int CF_BOR_EN = 3;
    localparam int CF_LVD_EN = 4;
    localparam int CF_PLL = 5;
    localparam int CF_LPOSC_SLP = 6;
    localparam int CF_COSC = 8;
    // Oscillator select codes
    localparam logic [1:0] OSC_EXT = 2'h0;
    localparam logic [1:0] OSC_FRC = 2'h1;
    localparam logic [1:0] OSC_LP = 2'h2;
    localparam logic [1:0] OSC_XTAL = 2'h3;
    localparam logic [31:0] CONFIG_RST = 32'h0000_0000;
    localparam logic [15:0] PERIPH_RST = 16'h0000;
    typedef enum logic [2:0] {
        ST_RUN = 3'b000,
        ST_IDLE_S = 3'b001,
        ST_SLEEP_S = 3'b010,
        ST_WAKE = 3'b011,
        ST_WCLK = 3'b100
    } sipc_state_t;
endpackage
`default_nettype wire

// ==== rtl/sipc_top.sv ====
/*
 * Sleep/idle power controller: gates CPU and peripheral clocks, stops
 * oscillators in sleep, times the wake delays and keeps the status flags.
 * Assumes the CPU core pulses the power-save instruction, the interrupt
 * controller qualifies enable and priority, and the oscillator logic
 * reports running and pll lock levels. Registers over classic Wishbone.
 */
// The placing of the registers and the Wishbone register port are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// RQ1: Power-save instruction operand picks sleep or idle
// RQ2: Sleep stops CPU, peripheral clocks and oscillator
// RQ3: Monitor off in sleep; LOW_POWER_RC_OSC runs with watchdog
// RQ4: Brownout and voltage detect stay on in sleep
// RQ5: Sleep ends on interrupt, reset or watchdog
// RQ6: Wake restarts previous clock selection
// RQ7: Poweron or brownout picks oscillator from fuses
// RQ8: Crystal waits startup timer, PLL waits lock; here lock is checked only on crystal wakes, not with RC or external clocks
// RQ9: RC or external clocks use only por delay
// RQ10: LP crystal kept running uses por delay only
// RQ11: Interrupt wake from sleep sets sleep flag
// RQ12: Dead crystal: trap and FAST_RC_OSC, else suspend
// RQ13: Non-poweron resets set sleep flag; poweron clears
// RQ14: Watchdog wake from sleep sets sleep, timeout
// RQ15: Idle stops only the CPU clock; here idle also stops each peripheral whose PERIPH bit is clear
// RQ16: Per-peripheral bit keeps it running in idle
// RQ17: Monitor stays active in idle when enabled
// RQ18: Idle ends on interrupt, reset or watchdog
// RQ19: Idle wake is immediate, resumes next instruction
// RQ20: Interrupt wake from idle sets idle flag
// RQ21: Watchdog wake from idle sets idle, timeout
// RQ22: Watchdog resets when running, only wakes sleeping
// RQ23: One low-power state at a time, from run
module sipc_top #(
    parameter int POWERUP_TIMER_CYC = sipc_pkg::POWERUP_TIMER_DELAY_CYC
) (
    input wire logic clk_sys_i,
    input wire logic rstn_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    output logic wb_err_o,
    input wire logic power_save_instruction_i,
    input wire logic power_save_sleep_i,
    input wire logic irq_wake_i,
    input wire logic watchdog_timeout_i,
    input wire logic reset_event_i,
    input wire logic por_event_i,
    input wire logic bor_event_i,
    input wire logic [1:0] osc_family_fuse_i,
    input wire logic [3:0] primary_osc_mode_fuse_i,
    input wire logic osc_running_i,
    input wire logic pll_locked_i,
    output logic cpu_clk_en_o,
    output logic [15:0] periph_clk_en_o,
    output logic osc_en_o,
    output logic low_power_rc_osc_en_o,
    output logic failsafe_clock_monitor_active_o,
    output logic bor_active_o,
    output logic lvd_active_o,
    output logic irq_vector_o,
    output logic clock_fail_trap_o,
    output logic frc_force_o,
    output logic watchdog_reset_o,
    output logic [1:0] wake_osc_o
);
    typedef struct packed {
        sipc_pkg::sipc_state_t st;
        logic [sipc_pkg::CNT_W-1:0] cnt;
        logic need_ost;
        logic wake_irq;
        logic [31:0] cfg;
        logic [15:0] periph;
        logic flag_sleep;
        logic flag_idle;
        logic flag_watchdog_timeout_flag;
        logic ack;
        logic err;
        logic [31:0] rdat;
        logic vec;
        logic trap;
        logic fast_rc_osc;
        logic wdt_rst;
    } sipc_regs_t;

    sipc_regs_t s_q;
    sipc_regs_t s_d;
    logic [1:0] osc_sel;
    logic fast_wake;
    logic wake_ev;
    logic [31:0] status_word;

    // Merge a write word into a register under byte enables
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] sel);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (sel[i]) begin
                r[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
        return r;
    endfunction

    // Wake clock: kept COSC selection when CLKSW is set, else the fuses
    always_comb begin
        if (s_q.cfg[sipc_pkg::CF_CLKSW]) begin
            osc_sel = s_q.cfg[sipc_pkg::CF_COSC +: 2]; // [RQ6]
        end else begin
            osc_sel = osc_family_fuse_i; // [RQ6]
        end
        // LP crystal kept running through sleep needs no startup wait
        fast_wake = (osc_sel != sipc_pkg::OSC_XTAL)
            && !(osc_sel == sipc_pkg::OSC_LP && !s_q.cfg[sipc_pkg::CF_LPOSC_SLP]); // [RQ9] [RQ10]
    end

    assign wake_ev = irq_wake_i || watchdog_timeout_i;
    assign status_word = {27'h000_0000, s_q.flag_watchdog_timeout_flag, s_q.flag_sleep, s_q.flag_idle, 2'h0};

    // Next-state logic for the whole block
    always_comb begin
        s_d = s_q;
        s_d.ack = 1'b0;
        s_d.err = 1'b0;
        s_d.vec = 1'b0;
        s_d.wdt_rst = 1'b0;
        s_d.trap = 1'b0;

        // Register slave; ack drops the cycle after it is given
        if (wb_cyc_i && wb_stb_i && !s_q.ack && !s_q.err) begin
            unique case (wb_adr_i)
                sipc_pkg::REG_CTRL: begin
                    s_d.ack = 1'b1;
                    s_d.rdat = {29'h0000_0000, s_q.st};
                end
                sipc_pkg::REG_STATUS: begin
                    s_d.ack = 1'b1;
                    s_d.rdat = status_word;
                    if (wb_we_i && wb_sel_i[0]) begin
                        s_d.flag_watchdog_timeout_flag = wb_dat_i[sipc_pkg::ST_WATCHDOG_TIMEOUT_FLAG];
                        s_d.flag_sleep = wb_dat_i[sipc_pkg::ST_SLEEP];
                        s_d.flag_idle = wb_dat_i[sipc_pkg::ST_IDLE];
                    end
                end
                sipc_pkg::REG_CONFIG: begin
                    s_d.ack = 1'b1;
                    s_d.rdat = s_q.cfg;
                    if (wb_we_i) begin
                        s_d.cfg = merge(s_q.cfg, wb_dat_i, wb_sel_i);
                    end
                end
                sipc_pkg::REG_PERIPH: begin
                    s_d.ack = 1'b1;
                    s_d.rdat = {16'h0000, s_q.periph};
                    if (wb_we_i) begin
                        s_d.periph = 16'(merge({16'h0000, s_q.periph}, wb_dat_i, wb_sel_i));
                    end
                end
                default: begin
                    s_d.err = 1'b1;
                    s_d.rdat = 32'h0000_0000;
                end
            endcase
        end

        // Power state machine
        unique case (s_q.st)
            sipc_pkg::ST_RUN: begin
                if (watchdog_timeout_i) begin
                    s_d.wdt_rst = 1'b1; // [RQ22]
                    s_d.flag_watchdog_timeout_flag = 1'b1;
                end else if (power_save_instruction_i) begin
                    // Only accepted while running
                    s_d.st = power_save_sleep_i ? sipc_pkg::ST_SLEEP_S
                                                : sipc_pkg::ST_IDLE_S; // [RQ1] [RQ23]
                end
            end
            sipc_pkg::ST_IDLE_S: begin
                if (wake_ev) begin
                    s_d.st = sipc_pkg::ST_RUN; // [RQ18] [RQ19]
                    s_d.flag_idle = 1'b1; // [RQ20] [RQ21]
                    s_d.vec = irq_wake_i;
                    if (watchdog_timeout_i) begin
                        s_d.flag_watchdog_timeout_flag = 1'b1; // [RQ21]
                    end
                end
            end
            sipc_pkg::ST_SLEEP_S: begin
                if (wake_ev) begin
                    s_d.st = sipc_pkg::ST_WAKE; // [RQ5]
                    s_d.flag_sleep = 1'b1; // [RQ11] [RQ14]
                    s_d.wake_irq = irq_wake_i;
                    s_d.need_ost = !fast_wake; // [RQ8]
                    s_d.cnt = fast_wake ? sipc_pkg::CNT_W'(sipc_pkg::POR_DELAY_CYC)
                        : sipc_pkg::CNT_W'(sipc_pkg::POR_DELAY_CYC + POWERUP_TIMER_CYC
                                           + sipc_pkg::OST_CYCLES); // [RQ8] [RQ9]
                    if (watchdog_timeout_i) begin
                        s_d.flag_watchdog_timeout_flag = 1'b1; // [RQ14] [RQ22]
                    end
                end
            end
            sipc_pkg::ST_WAKE: begin
                if (s_q.cnt > 1) begin
                    s_d.cnt = s_q.cnt - 1'b1;
                end else if (s_q.need_ost && (!osc_running_i
                         || (s_q.cfg[sipc_pkg::CF_PLL] && !pll_locked_i))) begin
                    if (s_q.cfg[sipc_pkg::CF_FAILSAFE_CLOCK_MONITOR_EN]) begin
                        s_d.trap = 1'b1; // [RQ12]
                        s_d.fast_rc_osc = 1'b1;
                        s_d.st = sipc_pkg::ST_RUN;
                    end else begin
                        s_d.st = sipc_pkg::ST_WCLK; // [RQ12]
                    end
                end else begin
                    s_d.st = sipc_pkg::ST_RUN;
                    s_d.vec = s_q.wake_irq; // [RQ11]
                end
            end
            sipc_pkg::ST_WCLK: begin
                // Suspended until the crystal and PLL are good
                if (osc_running_i && (!s_q.cfg[sipc_pkg::CF_PLL] || pll_locked_i)) begin
                    s_d.st = sipc_pkg::ST_RUN; // [RQ12]
                    s_d.vec = s_q.wake_irq;
                end
            end
            default: begin
                s_d.st = sipc_pkg::ST_RUN;
            end
        endcase

        // Any reset wakes; poweron clears flags, others mark the state
        if (reset_event_i || por_event_i || bor_event_i) begin
            s_d.st = sipc_pkg::ST_RUN; // [RQ5] [RQ18]
            s_d.fast_rc_osc = 1'b0;
            if (por_event_i) begin
                s_d.flag_sleep = 1'b0; // [RQ13] [RQ20]
                s_d.flag_idle = 1'b0;
                s_d.flag_watchdog_timeout_flag = 1'b0;
            end else begin
                // Build on s_d so a same-cycle software write is not lost
                s_d.flag_sleep = s_d.flag_sleep || (s_q.st != sipc_pkg::ST_RUN
                    && s_q.st != sipc_pkg::ST_IDLE_S); // [RQ13]
                s_d.flag_idle = s_d.flag_idle || (s_q.st == sipc_pkg::ST_IDLE_S); // [RQ20]
            end
            if (por_event_i || bor_event_i) begin
                // Fuses decide the oscillator, not the old selection
                s_d.cfg[sipc_pkg::CF_COSC +: 2] = osc_family_fuse_i; // [RQ7]
                s_d.cfg[sipc_pkg::CF_PLL] = primary_osc_mode_fuse_i[3]; // [RQ7]
            end
        end
    end

    // Single register bank for all state
    always_ff @(posedge clk_sys_i) begin
        if (!rstn_i) begin
            s_q <= '{st: sipc_pkg::ST_RUN, cnt: '0, need_ost: 1'b0, wake_irq: 1'b0,
                     cfg: sipc_pkg::CONFIG_RST, periph: sipc_pkg::PERIPH_RST,
                     flag_sleep: 1'b0, flag_idle: 1'b0, flag_watchdog_timeout_flag: 1'b0, ack: 1'b0,
                     err: 1'b0, rdat: 32'h0000_0000, vec: 1'b0, trap: 1'b0, fast_rc_osc: 1'b0,
                     wdt_rst: 1'b0};
        end else begin
            s_q <= s_d;
        end
    end

    // Clock gating and analog enables
    logic sleeping;
    assign sleeping = (s_q.st == sipc_pkg::ST_SLEEP_S) || (s_q.st == sipc_pkg::ST_WAKE)
                      || (s_q.st == sipc_pkg::ST_WCLK);
    assign cpu_clk_en_o = (s_q.st == sipc_pkg::ST_RUN); // [RQ2] [RQ15]
    assign periph_clk_en_o = sleeping ? 16'h0000
        : ((s_q.st == sipc_pkg::ST_IDLE_S) ? s_q.periph : 16'hFFFF); // [RQ2] [RQ16]
    // LP crystal may be told to keep running through sleep
    assign osc_en_o = !(s_q.st == sipc_pkg::ST_SLEEP_S)
        || (osc_sel == sipc_pkg::OSC_LP && s_q.cfg[sipc_pkg::CF_LPOSC_SLP]); // [RQ2] [RQ10]
    assign low_power_rc_osc_en_o = !sleeping || s_q.cfg[sipc_pkg::CF_WDT_EN]; // [RQ3]
    assign failsafe_clock_monitor_active_o = s_q.cfg[sipc_pkg::CF_FAILSAFE_CLOCK_MONITOR_EN] && !sleeping; // [RQ3] [RQ17]
    assign bor_active_o = s_q.cfg[sipc_pkg::CF_BOR_EN]; // [RQ4]
    assign lvd_active_o = s_q.cfg[sipc_pkg::CF_LVD_EN]; // [RQ4]
    assign irq_vector_o = s_q.vec;
    assign clock_fail_trap_o = s_q.trap;
    assign frc_force_o = s_q.fast_rc_osc;
    assign watchdog_reset_o = s_q.wdt_rst;
    assign wake_osc_o = osc_sel;
    assign wb_dat_o = s_q.rdat;
    assign wb_ack_o = s_q.ack;
    assign wb_err_o = s_q.err;
endmodule
`default_nettype wire

// ==== tb/sipc_checker.sv ====
/* Port-level assertions for sipc_top, bound to every instance.
   Assumes one clock domain and the synchronous active-low reset. */
`timescale 1ns/1ps
`default_nettype none
module sipc_checker #(
    parameter int POWERUP_TIMER_CYC = 10
) (
    input wire logic clk_sys_i,
    input wire logic rstn_i,
    input wire logic power_save_instruction_i,
    input wire logic power_save_sleep_i,
    input wire logic irq_wake_i,
    input wire logic watchdog_timeout_i,
    input wire logic reset_event_i,
    input wire logic por_event_i,
    input wire logic bor_event_i,
    input wire logic cpu_clk_en_o,
    input wire logic [15:0] periph_clk_en_o,
    input wire logic osc_en_o,
    input wire logic failsafe_clock_monitor_active_o,
    input wire logic irq_vector_o,
    input wire logic watchdog_reset_o
);
    localparam int WAKE_MIN = sipc_pkg::POR_DELAY_CYC - 1;
    logic rst_ev, quiet, slp_q, idl_q, wk_q;
    logic [15:0] cnt_q;
    assign rst_ev = reset_event_i | por_event_i | bor_event_i;
    assign quiet = !rst_ev && !irq_wake_i && !watchdog_timeout_i;
    // Shadow of the low-power state; any reset event wipes it
    always_ff @(posedge clk_sys_i) begin
        if (!rstn_i || rst_ev) begin
            slp_q <= 1'b0;
            idl_q <= 1'b0;
            wk_q <= 1'b0;
            cnt_q <= 16'h0000;
        end else if (cpu_clk_en_o) begin
            slp_q <= power_save_instruction_i && power_save_sleep_i && quiet;
            idl_q <= power_save_instruction_i && !power_save_sleep_i && quiet;
            wk_q <= 1'b0;
        end else if (slp_q && !quiet) begin
            slp_q <= 1'b0;
            wk_q <= 1'b1;
            cnt_q <= 16'h0000;
        end else if (idl_q && !quiet) begin
            idl_q <= 1'b0;
        end else if (wk_q) begin
            cnt_q <= cnt_q + 16'h0001;
        end
    end
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (!rstn_i);
    // Entry steps, one per low-power state
    sequence s_enter_sleep;
        cpu_clk_en_o && power_save_instruction_i && power_save_sleep_i && quiet;
    endsequence
    sequence s_enter_idle;
        cpu_clk_en_o && power_save_instruction_i && !power_save_sleep_i && quiet;
    endsequence
    property p_sleep_gate;
        s_enter_sleep |=> !cpu_clk_en_o && periph_clk_en_o == 16'h0000;
    endproperty
    a_sleep_gate: assert property (p_sleep_gate) else $error("sleep left a clock on");
    property p_idle_gate;
        s_enter_idle |=> !cpu_clk_en_o && osc_en_o;
    endproperty
    a_idle_gate: assert property (p_idle_gate) else $error("idle gating wrong");
    property p_sleep_hold;
        slp_q && quiet |=> !cpu_clk_en_o && periph_clk_en_o == 16'h0000;
    endproperty
    a_sleep_hold: assert property (p_sleep_hold) else $error("sleep left early");
    property p_failsafe_clock_monitor_off;
        !osc_en_o |-> !failsafe_clock_monitor_active_o;
    endproperty
    a_failsafe_clock_monitor_off: assert property (p_failsafe_clock_monitor_off) else $error("monitor on in sleep");
    property p_idle_wake;
        idl_q && irq_wake_i && !rst_ev |=> cpu_clk_en_o && irq_vector_o;
    endproperty
    a_idle_wake: assert property (p_idle_wake) else $error("idle wake late");
    property p_idle_wdt;
        idl_q && watchdog_timeout_i && !rst_ev |=> cpu_clk_en_o && !watchdog_reset_o;
    endproperty
    a_idle_wdt: assert property (p_idle_wdt) else $error("idle watchdog wake wrong");
    property p_wake_delay;
        wk_q && cnt_q < WAKE_MIN |-> !cpu_clk_en_o;
    endproperty
    a_wake_delay: assert property (p_wake_delay) else $error("sleep wake too soon");
    property p_wdt_sleep;
        slp_q && watchdog_timeout_i |=> !watchdog_reset_o;
    endproperty
    a_wdt_sleep: assert property (p_wdt_sleep) else $error("watchdog reset in sleep");
    property p_wdt_run;
        cpu_clk_en_o && watchdog_timeout_i && !power_save_instruction_i && !rst_ev
            |=> watchdog_reset_o;
    endproperty
    a_wdt_run: assert property (p_wdt_run) else $error("no watchdog reset in run");
    property p_reset_wake;
        rst_ev |=> cpu_clk_en_o;
    endproperty
    a_reset_wake: assert property (p_reset_wake) else $error("reset did not wake");
endmodule
bind sipc_top sipc_checker #(.POWERUP_TIMER_CYC(POWERUP_TIMER_CYC)) u_chk (.clk_sys_i, .rstn_i,
    .power_save_instruction_i, .power_save_sleep_i, .irq_wake_i, .watchdog_timeout_i,
    .reset_event_i, .por_event_i, .bor_event_i, .cpu_clk_en_o, .periph_clk_en_o,
    .osc_en_o, .failsafe_clock_monitor_active_o, .irq_vector_o, .watchdog_reset_o);
`default_nettype wire

// ==== tb/sipc_osc_model.sv ====
/* Oscillator model: answers enable with running, then pll lock.
   Assumes the controller's clock; dead_i models a crystal that never starts. */
`timescale 1ns/1ps
`default_nettype none
module sipc_osc_model #(
    parameter int START_CYC = 20
) (
    input wire logic clk_sys_i,
    input wire logic osc_en_i,
    input wire logic dead_i,
    output logic osc_running_o,
    output logic pll_locked_o
);
    int cnt;
    // Start-up count restarts whenever the enable drops
    always @(posedge clk_sys_i) begin
        if (!osc_en_i || dead_i) begin
            cnt <= 0;
        end else if (cnt < START_CYC + 4) begin
            cnt <= cnt + 1;
        end
    end
    // Lock trails running, so a wake that skips the lock wait shows up
    assign osc_running_o = osc_en_i && !dead_i && cnt >= START_CYC;
    assign pll_locked_o = osc_running_o && cnt >= START_CYC + 4;
endmodule
`default_nettype wire

// ==== tb/tb.sv ====
/* Self-checking bench for sipc_top: Wishbone tasks, event pulses, wake timing.
   Assumes the oscillator model on the far side and the bound checker. */
`timescale 1ns/1ps
`default_nettype none
module tb;
    localparam int POWERUP_TIMER = 10;
    localparam int POR = sipc_pkg::POR_DELAY_CYC;
    localparam int SLOW = POR + POWERUP_TIMER + sipc_pkg::OST_CYCLES;
    logic clk_sys_i = 1'b0;
    logic rstn_i, wb_cyc_i, wb_stb_i, wb_we_i, e, dead;
    logic [7:0] wb_adr_i;
    logic [3:0] wb_sel_i;
    logic [31:0] wb_dat_i, wb_dat_o, q;
    logic wb_ack_o, wb_err_o, osc_running_i, pll_locked_i, cpu_clk_en_o, osc_en_o;
    logic low_power_rc_osc_en_o, failsafe_clock_monitor_active_o, bor_active_o, lvd_active_o, irq_vector_o;
    logic clock_fail_trap_o, frc_force_o, watchdog_reset_o;
    logic [15:0] periph_clk_en_o;
    logic [1:0] osc_family_fuse_i, wake_osc_o;
    logic [6:0] evt;
    logic [31:0] cfg [3] = '{32'h0000_011F, 32'h0000_033B, 32'h0000_025B};
    int dly [3] = '{POR, SLOW, POR};
    int wk [3] = '{2, 3, 2};
    logic [31:0] st [3] = '{32'h0000_0008, 32'h0000_0018, 32'h0000_0008};
    int error_cnt, n_compared, vec_n, trap_n, wrst_n, k, n;
    sipc_top #(.POWERUP_TIMER_CYC(POWERUP_TIMER)) DUT (.clk_sys_i, .rstn_i, .wb_cyc_i, .wb_stb_i,
        .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .wb_err_o,
        .power_save_instruction_i(evt[0] | evt[1]), .power_save_sleep_i(evt[1]),
        .irq_wake_i(evt[2]), .watchdog_timeout_i(evt[3]), .reset_event_i(evt[4]),
        .por_event_i(evt[5]), .bor_event_i(evt[6]), .osc_family_fuse_i,
        .primary_osc_mode_fuse_i(4'h0), .osc_running_i, .pll_locked_i, .cpu_clk_en_o,
        .periph_clk_en_o, .osc_en_o, .low_power_rc_osc_en_o, .failsafe_clock_monitor_active_o, .bor_active_o,
        .lvd_active_o, .irq_vector_o, .clock_fail_trap_o, .frc_force_o,
        .watchdog_reset_o, .wake_osc_o);
    sipc_osc_model u_osc (.clk_sys_i, .osc_en_i(osc_en_o), .dead_i(dead),
        .osc_running_o(osc_running_i), .pll_locked_o(pll_locked_i));
    always #10 clk_sys_i = ~clk_sys_i;
    // Pulse counters; registered pulses are read at the edge after them
    always @(posedge clk_sys_i) begin
        vec_n += irq_vector_o;
        trap_n += clock_fail_trap_o;
        wrst_n += watchdog_reset_o;
    end
    task automatic complete_run();
        $display("compared %0d mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] g);
        n_compared++;
        if (g !== x) begin
            error_cnt++;
            $display("MISMATCH %s expected %h seen %h", nm, x, g);
        end
    endtask
    // One classic cycle; request held until ack or err is sampled high
    task automatic bus(input logic we, input logic [7:0] a, input logic [31:0] d);
        int t;
        t = 0;
        @(posedge clk_sys_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= a;
        wb_dat_i <= d;
        do begin
            @(posedge clk_sys_i);
            t++;
        end while (wb_ack_o !== 1'b1 && wb_err_o !== 1'b1 && t < 50);
        q = wb_dat_o;
        e = wb_err_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        #1;
        chk("bus_answer", 1, t < 50);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] x);
        bus(1'b0, a, 32'h0000_0000);
        chk($sformatf("reg_%h", a), x, q);
    endtask
    task automatic ev(input int b);
        @(posedge clk_sys_i);
        evt <= 7'h01 << b;
        @(posedge clk_sys_i);
        evt <= 7'h00;
        #1;
    endtask
    task automatic wait_cpu(input int lim);
        n = 0;
        while (cpu_clk_en_o !== 1'b1 && n < lim) begin
            @(posedge clk_sys_i);
            #1;
            n++;
        end
    endtask
    // Hang guard, well past the longest expected run
    initial begin
        #600000;
        error_cnt++;
        complete_run();
    end
    // Main sequence
    initial begin
        {rstn_i, wb_cyc_i, wb_stb_i, wb_we_i, dead, evt} = '0;
        wb_adr_i = 8'h00;
        wb_sel_i = 4'hF;
        wb_dat_i = 32'h0000_0000;
        osc_family_fuse_i = sipc_pkg::OSC_FRC;
        repeat (5) @(posedge clk_sys_i);
        rstn_i <= 1'b1;
        #1;
        chk("cpu_rst", 1, cpu_clk_en_o);
        chk("per_rst", 16'hFFFF, periph_clk_en_o);
        rd(sipc_pkg::REG_STATUS, 32'h0000_0000);
        bus(1'b0, 8'h40, 32'h0000_0000);
        chk("unmapped_err", 1, e);
        bus(1'b1, sipc_pkg::REG_CONFIG, 32'h0000_011B);
        rd(sipc_pkg::REG_CONFIG, 32'h0000_011B);
        chk("bor", 1, bor_active_o);
        chk("lvd", 1, lvd_active_o);
        bus(1'b1, sipc_pkg::REG_PERIPH, 32'h0000_00A5);
        k = vec_n;
        ev(0);
        chk("idle_cpu", 0, cpu_clk_en_o);
        chk("idle_per", 16'h00A5, periph_clk_en_o);
        chk("idle_osc", 1, osc_en_o);
        rd(sipc_pkg::REG_CTRL, 32'h0000_0001);
        ev(2);
        chk("idle_wake", 1, cpu_clk_en_o);
        rd(sipc_pkg::REG_STATUS, 32'h0000_0004);
        chk("idle_vec", k + 1, vec_n);
        bus(1'b1, sipc_pkg::REG_STATUS, 32'h0000_0000);
        k = wrst_n;
        ev(0);
        ev(3);
        chk("idle_wdt", 1, cpu_clk_en_o);
        rd(sipc_pkg::REG_STATUS, 32'h0000_0014);
        chk("idle_wrst", k, wrst_n);
        // Sleep wakes: fast clock, crystal with pll, low-power crystal kept
        for (int i = 0; i < 3; i++) begin
            bus(1'b1, sipc_pkg::REG_STATUS, 32'h0000_0000);
            bus(1'b1, sipc_pkg::REG_CONFIG, cfg[i]);
            k = vec_n;
            ev(1);
            chk("slp_cpu", 0, cpu_clk_en_o);
            chk("slp_per", 16'h0000, periph_clk_en_o);
            chk("slp_osc", i == 2, osc_en_o);
            chk("slp_low_power_rc_osc", 1, low_power_rc_osc_en_o);
            chk("slp_failsafe_clock_monitor", 0, failsafe_clock_monitor_active_o);
            ev(wk[i]);
            wait_cpu(4000);
            chk("wake_cyc", 1, n >= dly[i] && n <= dly[i] + 2);
            chk("wake_osc", cfg[i][9:8], wake_osc_o);
            rd(sipc_pkg::REG_STATUS, st[i]);
            chk("wake_vec", k + (wk[i] == 2), vec_n);
        end
        // Crystal that never starts: trap with monitor, else suspend
        bus(1'b1, sipc_pkg::REG_CONFIG, 32'h0000_033F);
        dead <= 1'b1;
        k = trap_n;
        ev(1);
        ev(2);
        wait_cpu(4000);
        @(posedge clk_sys_i);
        #1;
        chk("trap", k + 1, trap_n);
        chk("frc_force", 1, frc_force_o);
        ev(4);
        chk("frc_clear", 0, frc_force_o);
        bus(1'b1, sipc_pkg::REG_CONFIG, 32'h0000_033B);
        ev(1);
        ev(2);
        wait_cpu(3000);
        chk("suspend", 0, cpu_clk_en_o);
        dead <= 1'b0;
        wait_cpu(200);
        chk("resume", 1, cpu_clk_en_o);
        // Reset and brownout events wake sleep at once and set the sleep flag
        for (int r = 4; r <= 6; r += 2) begin
            bus(1'b1, sipc_pkg::REG_STATUS, 32'h0000_0000);
            ev(1);
            ev(r);
            chk("rst_wake", 1, cpu_clk_en_o);
            rd(sipc_pkg::REG_STATUS, 32'h0000_0008);
        end
        k = wrst_n;
        ev(3);
        @(posedge clk_sys_i);
        #1;
        chk("run_wrst", k + 1, wrst_n);
        ev(5);
        rd(sipc_pkg::REG_STATUS, 32'h0000_0000);
        chk("por_osc", sipc_pkg::OSC_FRC, wake_osc_o);
        complete_run();
    end
endmodule
`default_nettype wire
